// *** pkg/nvm_pkg.sv ***
// shared constants and types for the nonvolatile settings store controller
package nvm_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 12; // register space address
  localparam int DATA_W = 8; // register and nvm byte
  localparam int NVM_AW = 10; // nvm byte address
  localparam int SEG_ENTRIES = 23; // segment table length
  localparam int IDX_W = 5; // segment index width

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_XFER_BUSY = 12'h0b00; // progress flag
  localparam logic [ADDR_W-1:0] REG_DATA_ERR = 12'h0b01; // error flag
  localparam logic [ADDR_W-1:0] REG_RELOAD_WEN = 12'h0b02; // reload and write enable
  localparam logic [ADDR_W-1:0] REG_STORE = 12'h0b03; // store trigger

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int BIT_BUSY = 0; // progress flag bit
  localparam int BIT_ERR = 0; // error flag bit
  localparam int BIT_WEN = 0; // nvm write enable bit
  localparam int BIT_RELOAD = 1; // soft reload bit
  localparam int BIT_STORE = 0; // store trigger bit
  localparam logic RST_WEN = 1'b0; // write protection on after reset
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00; // cleared byte

  // ----------------------------------------
  // segment table
  // ----------------------------------------
  typedef enum logic [1:0] {SEG_COPY, SEG_APPLY, SEG_END} seg_op_t;

  typedef struct packed {
    seg_op_t op; // what the entry does
    logic [ADDR_W-1:0] start; // first register of the segment
    logic [DATA_W-1:0] count; // bytes in the segment
  } seg_entry_t;

  // default table: all settings blocks, then apply, then end
  localparam seg_entry_t SEG_TABLE [SEG_ENTRIES] = '{
    0: '{SEG_COPY, 12'h0000, 8'h04},
    1: '{SEG_COPY, 12'h0010, 8'h10},
    2: '{SEG_COPY, 12'h00f0, 8'h0c},
    3: '{SEG_COPY, 12'h0190, 8'h10},
    4: '{SEG_COPY, 12'h0230, 8'h01},
    5: '{SEG_APPLY, 12'h0000, 8'h00},
    default: '{SEG_END, 12'h0000, 8'h00}
  };

  // transfer engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_RD, ST_WT, ST_WR, ST_CK_RD, ST_CK_WT, ST_CK_CMP, ST_FIN
  } xfer_state_t;

endpackage : nvm_pkg

// *** pkg/nvm_xfer_if.sv ***
// control and status link between register front end and transfer engine
`timescale 1ns/1ps
interface nvm_xfer_if;
  logic start_store; // one-cycle pulse, copy buffer into nvm
  logic start_reload; // one-cycle pulse, copy nvm into buffer
  logic write_en; // level, nvm write protection lifted
  logic busy; // level, transfer in progress
  logic error; // level, last transfer saw bad data
  logic done; // one-cycle pulse, transfer finished
  logic apply; // one-cycle pulse, apply table entry reached during a reload

  modport ctl (output start_store, start_reload, write_en, input busy, error, done, apply);
  modport eng (input start_store, start_reload, write_en, output busy, error, done, apply);
endinterface : nvm_xfer_if

// *** hdl/nvm_xfer_engine.sv ***
// segment-table driven byte mover between buffer bank and nvm
`timescale 1ns/1ps
module nvm_xfer_engine (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control link
  nvm_xfer_if.eng xif,
  // buffer register bank
  output logic buf_re,
  output logic buf_we,
  output logic [nvm_pkg::ADDR_W-1:0] buf_addr,
  output logic [nvm_pkg::DATA_W-1:0] buf_wdata,
  input wire logic [nvm_pkg::DATA_W-1:0] buf_rdata,
  // nonvolatile memory
  output logic nvm_re,
  output logic nvm_we,
  output logic [nvm_pkg::NVM_AW-1:0] nvm_addr,
  output logic [nvm_pkg::DATA_W-1:0] nvm_wdata,
  input wire logic [nvm_pkg::DATA_W-1:0] nvm_rdata
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    nvm_pkg::xfer_state_t st; // sequencer state
    logic [nvm_pkg::IDX_W-1:0] idx; // next table entry
    logic [nvm_pkg::DATA_W-1:0] cnt; // bytes left in segment
    logic [nvm_pkg::ADDR_W-1:0] baddr; // buffer pointer
    logic [nvm_pkg::NVM_AW-1:0] naddr; // nvm pointer
    logic dir; // 1 store, 0 reload
    logic [nvm_pkg::DATA_W-1:0] sum; // running checksum
    logic busy, err, done, apply;
    logic buf_re, buf_we, nvm_re, nvm_we;
    logic [nvm_pkg::ADDR_W-1:0] buf_addr;
    logic [nvm_pkg::NVM_AW-1:0] nvm_addr;
    logic [nvm_pkg::DATA_W-1:0] wdata;
  } eng_state_t;

  localparam eng_state_t ENG_RST = '0; // idle, flags clear
  eng_state_t s_r, s_nxt;
  nvm_pkg::seg_entry_t ent; // entry at the index
  logic [nvm_pkg::DATA_W-1:0] data; // byte returned by the source

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.apply = 1'b0;
    s_nxt.buf_re = 1'b0;
    s_nxt.buf_we = 1'b0;
    s_nxt.nvm_re = 1'b0;
    s_nxt.nvm_we = 1'b0;
    ent = nvm_pkg::SEG_TABLE[s_r.idx];
    data = s_r.dir ? buf_rdata : nvm_rdata;
    case (s_r.st)
      nvm_pkg::ST_IDLE: begin
        // store needs write enable; reload always allowed
        if ((xif.start_store && xif.write_en) || xif.start_reload) begin
          s_nxt.dir = xif.start_store;
          s_nxt.idx = '0;
          s_nxt.naddr = '0;
          s_nxt.sum = nvm_pkg::BYTE_ZERO;
          s_nxt.busy = 1'b1;
          s_nxt.st = nvm_pkg::ST_FETCH;
        end
      end
      nvm_pkg::ST_FETCH: begin
        // running off the table end counts as end of data
        if (32'(s_r.idx) >= nvm_pkg::SEG_ENTRIES || ent.op == nvm_pkg::SEG_END) begin
          s_nxt.st = nvm_pkg::ST_CK_RD;
        end else begin
          s_nxt.idx = s_r.idx + 1'b1;
          if (ent.op == nvm_pkg::SEG_APPLY) begin
            s_nxt.apply = !s_r.dir;
          end else if (ent.count != nvm_pkg::BYTE_ZERO) begin
            s_nxt.baddr = ent.start;
            s_nxt.cnt = ent.count;
            s_nxt.st = nvm_pkg::ST_RD;
          end
        end
      end
      nvm_pkg::ST_RD: begin
        // read the source side
        s_nxt.buf_re = s_r.dir;
        s_nxt.nvm_re = !s_r.dir;
        s_nxt.buf_addr = s_r.baddr;
        s_nxt.nvm_addr = s_r.naddr;
        s_nxt.st = nvm_pkg::ST_WT;
      end
      nvm_pkg::ST_WT: s_nxt.st = nvm_pkg::ST_WR; // one cycle read latency
      nvm_pkg::ST_WR: begin
        // write the far side; nvm writes stay gated by write enable
        s_nxt.nvm_we = s_r.dir && xif.write_en;
        s_nxt.buf_we = !s_r.dir;
        s_nxt.wdata = data;
        s_nxt.sum = s_r.sum + data;
        s_nxt.baddr = s_r.baddr + 1'b1;
        s_nxt.naddr = s_r.naddr + 1'b1;
        s_nxt.cnt = s_r.cnt - 1'b1;
        s_nxt.st = (s_r.cnt == 8'h01) ? nvm_pkg::ST_FETCH : nvm_pkg::ST_RD;
      end
      nvm_pkg::ST_CK_RD: begin
        // checksum byte follows the data in nvm
        s_nxt.nvm_addr = s_r.naddr;
        s_nxt.wdata = s_r.sum;
        s_nxt.nvm_we = s_r.dir && xif.write_en;
        s_nxt.nvm_re = !s_r.dir;
        s_nxt.st = nvm_pkg::ST_CK_WT;
      end
      nvm_pkg::ST_CK_WT: s_nxt.st = nvm_pkg::ST_CK_CMP;
      nvm_pkg::ST_CK_CMP: begin
        // error settles a cycle before busy drops
        s_nxt.err = !s_r.dir && (nvm_rdata != s_r.sum);
        s_nxt.st = nvm_pkg::ST_FIN;
      end
      nvm_pkg::ST_FIN: begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st = nvm_pkg::ST_IDLE;
      end
      default: s_nxt = ENG_RST;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= ENG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign xif.busy = s_r.busy;
  assign xif.error = s_r.err;
  assign xif.done = s_r.done;
  assign xif.apply = s_r.apply;
  assign buf_re = s_r.buf_re;
  assign buf_we = s_r.buf_we;
  assign buf_addr = s_r.buf_addr;
  assign buf_wdata = s_r.wdata;
  assign nvm_re = s_r.nvm_re;
  assign nvm_we = s_r.nvm_we;
  assign nvm_addr = s_r.nvm_addr;
  assign nvm_wdata = s_r.wdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_write_protect: assert property (nvm_we |-> $past(xif.write_en))
    else $error("nvm written while protected");
  a_busy_start: assert property (s_r.st == nvm_pkg::ST_IDLE && xif.start_reload
    |=> xif.busy)
    else $error("progress flag late");
  a_err_first: assert property ($fell(xif.busy)
    |-> $past(s_r.st, 2) == nvm_pkg::ST_CK_CMP)
    else $error("busy cleared before error update");
  a_apply_busy: assert property (xif.apply |-> xif.busy && !s_r.dir)
    else $error("apply outside reload");

endmodule : nvm_xfer_engine

// *** hdl/nvm_store_ctl.sv ***
// register front end and status pin for the nonvolatile settings store
// Functional notes
// - progress flag high while any transfer runs
// - status pin shows progress when selected
// - error flag reports bad transfer data
// - soft reload resets then applies stored settings
// - reload bit clears one clock after write
// - nvm writes blocked unless enable bit set
// - store bit starts copy, clears when done
// - segment table steers every transfer
// - apply bit copies buffer into active registers
`timescale 1ns/1ps
module nvm_store_ctl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // serial control port register access
  input wire logic [nvm_pkg::ADDR_W-1:0] host_addr,
  input wire logic [nvm_pkg::DATA_W-1:0] host_wdata,
  input wire logic host_wr,
  output logic [nvm_pkg::DATA_W-1:0] host_rdata,
  // pins and system controls
  input wire logic nvm_sel_n,
  input wire logic status_sel,
  input wire logic apply_req,
  output logic status_pin,
  output logic soft_reset,
  output logic apply_update,
  // buffer register bank
  output logic buf_re,
  output logic buf_we,
  output logic [nvm_pkg::ADDR_W-1:0] buf_addr,
  output logic [nvm_pkg::DATA_W-1:0] buf_wdata,
  input wire logic [nvm_pkg::DATA_W-1:0] buf_rdata,
  // nonvolatile memory
  output logic nvm_re,
  output logic nvm_we,
  output logic [nvm_pkg::NVM_AW-1:0] nvm_addr,
  output logic [nvm_pkg::DATA_W-1:0] nvm_wdata,
  input wire logic [nvm_pkg::DATA_W-1:0] nvm_rdata
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic sel_s1; // pin sync, first stage
    logic sel_s2; // pin sync, second stage
    logic wen; // nvm write enable
    logic reload; // soft reload bit, self clearing
    logic store; // store trigger bit
    logic start_store; // engine kick
    logic start_reload; // engine kick
    logic soft_rst; // device reset pulse
    logic apply; // active register update pulse
    logic status; // status pin
    logic [nvm_pkg::DATA_W-1:0] rdata; // read data
  } ctl_state_t;

  // sync stages start at the pin's idle, deselected level, so no reload
  // can slip through in the two cycles before the pin is really sampled
  localparam ctl_state_t CTL_RST = '{sel_s1: 1'b1, sel_s2: 1'b1,
    wen: nvm_pkg::RST_WEN, default: '0}; // write protection on after reset
  ctl_state_t s_r, s_nxt;
  nvm_xfer_if xif ();
  logic wr_reload; // write to reload/enable register
  logic wr_store; // write to store register

  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  nvm_xfer_engine u_engine (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .xif(xif.eng),
    .buf_re(buf_re),
    .buf_we(buf_we),
    .buf_addr(buf_addr),
    .buf_wdata(buf_wdata),
    .buf_rdata(buf_rdata),
    .nvm_re(nvm_re),
    .nvm_we(nvm_we),
    .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata),
    .nvm_rdata(nvm_rdata)
  );

  assign xif.start_store = s_r.start_store;
  assign xif.start_reload = s_r.start_reload;
  assign xif.write_en = s_r.wen;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    wr_reload = host_wr && host_addr == nvm_pkg::REG_RELOAD_WEN;
    wr_store = host_wr && host_addr == nvm_pkg::REG_STORE;
    // pin passes two flops before use
    s_nxt.sel_s1 = nvm_sel_n;
    s_nxt.sel_s2 = s_r.sel_s1;
    s_nxt.start_store = 1'b0;
    s_nxt.start_reload = 1'b0;
    s_nxt.soft_rst = 1'b0;
    // reload bit lives one clock past its write
    s_nxt.reload = 1'b0;
    if (wr_reload) begin
      // a refused reload still shows its bit for one cycle
      s_nxt.wen = host_wdata[nvm_pkg::BIT_WEN];
      s_nxt.reload = host_wdata[nvm_pkg::BIT_RELOAD];
      // reload only with the select pin low and engine idle
      if (host_wdata[nvm_pkg::BIT_RELOAD] && !s_r.sel_s2 && !xif.busy) begin
        s_nxt.soft_rst = 1'b1;
        s_nxt.start_reload = 1'b1;
      end
    end
    // store bit held until the engine reports done; set beats clear
    if (xif.done) begin
      s_nxt.store = 1'b0;
    end
    if (wr_store && host_wdata[nvm_pkg::BIT_STORE] && s_r.wen && !xif.busy) begin
      s_nxt.store = 1'b1;
      s_nxt.start_store = 1'b1;
    end
    // host apply request or table apply entry
    s_nxt.apply = apply_req || xif.apply;
    // status pin source select
    s_nxt.status = status_sel && xif.busy;
    // registered read data, unmapped reads as zero
    case (host_addr)
      nvm_pkg::REG_XFER_BUSY: begin
        s_nxt.rdata = nvm_pkg::BYTE_ZERO;
        s_nxt.rdata[nvm_pkg::BIT_BUSY] = xif.busy;
      end
      nvm_pkg::REG_DATA_ERR: begin
        s_nxt.rdata = nvm_pkg::BYTE_ZERO;
        s_nxt.rdata[nvm_pkg::BIT_ERR] = xif.error;
      end
      nvm_pkg::REG_RELOAD_WEN: begin
        s_nxt.rdata = nvm_pkg::BYTE_ZERO;
        s_nxt.rdata[nvm_pkg::BIT_WEN] = s_r.wen;
        s_nxt.rdata[nvm_pkg::BIT_RELOAD] = s_r.reload;
      end
      nvm_pkg::REG_STORE: begin
        s_nxt.rdata = nvm_pkg::BYTE_ZERO;
        s_nxt.rdata[nvm_pkg::BIT_STORE] = s_r.store;
      end
      default: s_nxt.rdata = nvm_pkg::BYTE_ZERO;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= CTL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign host_rdata = s_r.rdata;
  assign status_pin = s_r.status;
  assign soft_reset = s_r.soft_rst;
  assign apply_update = s_r.apply;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence seq_reload_write;
    wr_reload && host_wdata[nvm_pkg::BIT_RELOAD] && !s_r.sel_s2 && !xif.busy;
  endsequence

  sequence seq_reload_action;
    soft_reset && xif.start_reload ##1 !soft_reset ##1 xif.busy;
  endsequence

  a_soft_reload: assert property (seq_reload_write |=> seq_reload_action)
    else $error("soft reload sequence wrong");
  a_reload_clear: assert property (s_r.reload |=> !s_r.reload)
    else $error("reload bit did not self clear");
  a_status_pin: assert property (status_sel |=> status_pin == $past(xif.busy))
    else $error("status pin does not follow progress");
  a_busy_read: assert property (host_addr == nvm_pkg::REG_XFER_BUSY
    |=> host_rdata[nvm_pkg::BIT_BUSY] == $past(xif.busy))
    else $error("progress flag misread");
  a_err_read: assert property (host_addr == nvm_pkg::REG_DATA_ERR
    |=> host_rdata[nvm_pkg::BIT_ERR] == $past(xif.error))
    else $error("error flag misread");
  a_store_hold: assert property (wr_store && host_wdata[nvm_pkg::BIT_STORE]
    && s_r.wen && !xif.busy |=> s_r.store ##1 (s_r.store && xif.busy))
    else $error("store did not start");
  // a new store written in the done cycle wins over the clear
  a_store_clear: assert property (xif.done
    && !(wr_store && host_wdata[nvm_pkg::BIT_STORE]) |=> !s_r.store)
    else $error("store bit not cleared at end");
  // reload is allowed without write enable, only a store is locked out
  a_store_locked: assert property (!s_r.wen && !xif.busy
    && !xif.start_reload |=> !xif.busy)
    else $error("store ran while protected");
  a_apply_pulse: assert property (apply_req |=> apply_update)
    else $error("apply request lost");

  // refusals and register bits seen from the host side
  a_reload_refused: assert property (wr_reload && host_wdata[nvm_pkg::BIT_RELOAD]
    && s_r.sel_s2 |=> !soft_reset && !xif.start_reload)
    else $error("reload ran with select pin high");
  a_reload_set: assert property (wr_reload && host_wdata[nvm_pkg::BIT_RELOAD]
    |=> s_r.reload)
    else $error("reload bit not shown after write");
  a_wen_write: assert property (wr_reload
    |=> s_r.wen == $past(host_wdata[nvm_pkg::BIT_WEN]))
    else $error("write enable bit not taken");
  a_wen_read: assert property (host_addr == nvm_pkg::REG_RELOAD_WEN
    |=> host_rdata[nvm_pkg::BIT_WEN] == $past(s_r.wen))
    else $error("write enable misread");
  a_store_refused: assert property (wr_store && !s_r.wen |=> !xif.start_store)
    else $error("store kicked while protected");
  a_status_off: assert property (!status_sel |=> !status_pin)
    else $error("status pin driven while not selected");
  a_apply_source: assert property (apply_update |-> $past(apply_req) || $past(xif.apply))
    else $error("apply pulse without a cause");

endmodule : nvm_store_ctl

// *** verification/nvm_far_model.sv ***
// behavioural buffer register bank and nonvolatile memory beside the controller
`timescale 1ns/1ps
module nvm_far_model (
  // clock
  input wire logic ref_clk,
  // buffer register bank
  input wire logic buf_re,
  input wire logic buf_we,
  input wire logic [nvm_pkg::ADDR_W-1:0] buf_addr,
  input wire logic [nvm_pkg::DATA_W-1:0] buf_wdata,
  output logic [nvm_pkg::DATA_W-1:0] buf_rdata,
  // nonvolatile memory
  input wire logic nvm_re,
  input wire logic nvm_we,
  input wire logic [nvm_pkg::NVM_AW-1:0] nvm_addr,
  input wire logic [nvm_pkg::DATA_W-1:0] nvm_wdata,
  output logic [nvm_pkg::DATA_W-1:0] nvm_rdata
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] buf_mem [4096]; // buffer bank, whole register space
  logic [7:0] nvm_mem [1024]; // nonvolatile array

  // known pattern in the bank, nvm starts blank
  initial begin
    for (int a = 0; a < 4096; a++) buf_mem[a] = a[7:0] ^ 8'h5a;
    for (int a = 0; a < 1024; a++) nvm_mem[a] = 8'hff;
    buf_rdata = 8'h00;
    nvm_rdata = 8'h00;
  end

  // ----------------------------------------
  // one-cycle read latency, data stale after one cycle
  // ----------------------------------------
  // stale data is inverted so a late sample never passes by luck
  always @(posedge ref_clk) begin
    if (buf_re) buf_rdata <= buf_mem[buf_addr];
    else buf_rdata <= ~buf_rdata;
    if (buf_we) buf_mem[buf_addr] <= buf_wdata;
    if (nvm_re) nvm_rdata <= nvm_mem[nvm_addr];
    else nvm_rdata <= ~nvm_rdata;
    if (nvm_we) nvm_mem[nvm_addr] <= nvm_wdata;
  end
endmodule : nvm_far_model

// *** verification/tb_nvm_settings_store_control.sv ***
// self-checking bench for the nonvolatile settings store controller
`timescale 1ns/1ps
module tb_nvm_settings_store_control;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic ref_clk = 1'b0; // serial port clock
  logic sys_rst = 1'b1; // synchronous reset
  logic [11:0] host_addr = 12'h0000; // register address
  logic [7:0] host_wdata = 8'h00; // write data
  logic host_wr = 1'b0; // write strobe
  logic [7:0] host_rdata; // read data
  logic nvm_sel_n = 1'b1; // external select pin
  logic status_sel = 1'b1; // status pin shows progress
  logic apply_req = 1'b0; // apply bit write
  logic status_pin, soft_reset, apply_update;
  logic buf_re, buf_we, nvm_re, nvm_we;
  logic [11:0] buf_addr;
  logic [7:0] buf_wdata, buf_rdata, nvm_wdata, nvm_rdata;
  logic [9:0] nvm_addr;
  int err_count = 0; // mismatches
  int compares = 0; // comparisons
  int n_we = 0, n_soft = 0, n_apply = 0; // pulse counters
  logic [7:0] rv; // last read value
  bit ok; // wait result

  always #20 ref_clk = ~ref_clk; // 25 MHz

  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  nvm_store_ctl uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rdata(host_rdata),
    .nvm_sel_n(nvm_sel_n), .status_sel(status_sel), .apply_req(apply_req),
    .status_pin(status_pin), .soft_reset(soft_reset), .apply_update(apply_update),
    .buf_re(buf_re), .buf_we(buf_we), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
    .buf_rdata(buf_rdata), .nvm_re(nvm_re), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));
  nvm_far_model far (.ref_clk(ref_clk), .buf_re(buf_re), .buf_we(buf_we),
    .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
    .nvm_re(nvm_re), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_rdata(nvm_rdata));

  // pulse monitor, outputs are settled at the edge
  always @(posedge ref_clk) begin
    if (nvm_we === 1'b1) n_we++;
    if (soft_reset === 1'b1) n_soft++;
    if (apply_update === 1'b1) n_apply++;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // one register write, strobe held across one edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge ref_clk);
    #1 host_wr = 1'b0;
  endtask : wr

  // read data follows the address by one edge
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 host_addr = a;
    @(posedge ref_clk);
    #1 d = host_rdata;
  endtask : rd

  // bounded wait for the status pin to reach a level
  task automatic wait_pin(input logic lvl, input int lim, output bit hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge ref_clk);
      #1 hit = (status_pin === lvl);
    end
  endtask : wait_pin

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : pat

  task automatic test_done(input string name);
    $display("test %s done", name);
  endtask : test_done

  // the only exit of the run
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // tests need about 550 cycles, generous margin for slow transfers
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    end_sim;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [7:0] sum;
    int n;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    // reset values and unmapped space
    rd(12'h0b00, rv); check(rv, 8'h00, "progress after reset");
    rd(12'h0b01, rv); check(rv, 8'h00, "error after reset");
    rd(12'h0b02, rv); check(rv, 8'h00, "enable after reset");
    rd(12'h0b03, rv); check(rv, 8'h00, "store bit after reset");
    rd(12'h0123, rv); check(rv, 8'h00, "unmapped read");
    wr(12'h0b00, 8'hff); wr(12'h0b01, 8'hff);
    rd(12'h0b00, rv); check(rv, 8'h00, "read-only progress");
    rd(12'h0b01, rv); check(rv, 8'h00, "read-only error");
    test_done("reset");
    // store while write protected must not touch the nvm
    wr(12'h0b03, 8'h01);
    wait_pin(1'b1, 8, ok);
    check({7'd0, ok}, 8'h00, "protected store ran");
    check(8'(n_we), 8'h00, "protected nvm writes");
    test_done("protect");
    // enabled store copies the table segments and a checksum
    wr(12'h0b02, 8'h01);
    rd(12'h0b02, rv); check(rv, 8'h01, "enable readback");
    wr(12'h0b03, 8'h01);
    wait_pin(1'b1, 6, ok); check({7'd0, ok}, 8'h01, "store progress");
    rd(12'h0b00, rv); check(rv, 8'h01, "progress during store");
    rd(12'h0b03, rv); check(rv, 8'h01, "store bit during store");
    wait_pin(1'b0, 1000, ok); check({7'd0, ok}, 8'h01, "store end");
    rd(12'h0b03, rv); check(rv, 8'h00, "store bit cleared");
    rd(12'h0b01, rv); check(rv, 8'h00, "store error");
    sum = 8'h00;
    n = 0;
    for (int e = 0; e < nvm_pkg::SEG_ENTRIES; e++) begin
      if (nvm_pkg::SEG_TABLE[e].op == nvm_pkg::SEG_COPY) begin
        for (int k = 0; k < int'(nvm_pkg::SEG_TABLE[e].count); k++) begin
          check(far.nvm_mem[n], pat(nvm_pkg::SEG_TABLE[e].start + 12'(k)), "nvm byte");
          sum += pat(nvm_pkg::SEG_TABLE[e].start + 12'(k));
          n++;
        end
      end
    end
    check(far.nvm_mem[n], sum, "nvm checksum");
    check(8'(n_apply), 8'h00, "apply during store");
    test_done("store");
    // reload refused while the select pin is high
    wr(12'h0b02, 8'h02);
    wait_pin(1'b1, 6, ok);
    check({7'd0, ok}, 8'h00, "reload with pin high");
    check(8'(n_soft), 8'h00, "soft reset with pin high");
    test_done("reload refused");
    // reload with pin low restores a wiped bank
    for (int a = 0; a < 4096; a++) far.buf_mem[a] = 8'h00;
    #1 nvm_sel_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    wr(12'h0b02, 8'h02);
    rd(12'h0b02, rv); check(rv, 8'h00, "reload bit self clear");
    check(8'(n_soft), 8'h01, "soft reset pulse");
    wait_pin(1'b0, 1000, ok); check({7'd0, ok}, 8'h01, "reload end");
    rd(12'h0b01, rv); check(rv, 8'h00, "reload error");
    check(8'(n_apply), 8'h01, "apply from table");
    for (int e = 0; e < nvm_pkg::SEG_ENTRIES; e++) begin
      if (nvm_pkg::SEG_TABLE[e].op == nvm_pkg::SEG_COPY) begin
        for (int k = 0; k < int'(nvm_pkg::SEG_TABLE[e].count); k++) begin
          check(far.buf_mem[nvm_pkg::SEG_TABLE[e].start + 12'(k)],
            pat(nvm_pkg::SEG_TABLE[e].start + 12'(k)), "buffer byte");
        end
      end
    end
    test_done("reload");
    // corrupted nvm byte is flagged once progress falls
    far.nvm_mem[0] = far.nvm_mem[0] ^ 8'h01;
    #1 status_sel = 1'b0;
    wr(12'h0b02, 8'h02);
    repeat (20) @(posedge ref_clk);
    #1 check({7'd0, status_pin}, 8'h00, "pin not selected");
    rd(12'h0b00, rv); check(rv, 8'h01, "progress while pin off");
    #1 status_sel = 1'b1;
    wait_pin(1'b0, 1000, ok); check({7'd0, ok}, 8'h01, "bad reload end");
    rd(12'h0b01, rv); check(rv, 8'h01, "error flagged");
    test_done("bad data");
    // direct apply request gives one pulse next cycle
    n_apply = 0;
    @(posedge ref_clk);
    #1 apply_req = 1'b1;
    @(posedge ref_clk);
    #1 apply_req = 1'b0;
    check({7'd0, apply_update}, 8'h01, "apply pulse");
    @(posedge ref_clk);
    #1 check({7'd0, apply_update}, 8'h00, "apply pulse end");
    check(8'(n_apply), 8'h01, "apply pulse count");
    test_done("apply");
    end_sim;
  end
endmodule : tb_nvm_settings_store_control
